/* logic/iepc_pkg.sv */
// Purpose: Shared constants for the interrupt enable and low-power block.
// Assumes: APB with 32-bit data, one aligned word per register.
// Notes: Phase index 0 is state 1 phase 1; twelve phases form a cycle.
package iepc_pkg;
   localparam int ADDR_W = 8;
   // Register byte offsets.
   localparam logic [7:0] OFS_IRQ_EN = 8'h00;
   localparam logic [7:0] OFS_MODE = 8'h04;
   localparam logic [7:0] OFS_T2_FLAGS = 8'h08;
   localparam logic [7:0] OFS_STATUS = 8'h0c;
   // Interrupt enable mask bit positions.
   localparam int BIT_PIN0 = 0;
   localparam int BIT_T0 = 1;
   localparam int BIT_PIN1 = 2;
   localparam int BIT_T1 = 3;
   localparam int BIT_SERIAL = 4;
   localparam int BIT_T2 = 5;
   localparam int BIT_RSVD = 6;
   localparam int BIT_GLOBAL = 7;
   localparam logic [7:0] IRQ_EN_RESET = 8'h00;
   localparam logic [7:0] IRQ_EN_WMASK = 8'hbf;
   localparam int NUM_SOURCES = 6;
   // Mode control bit positions.
   localparam int BIT_IDLE = 0;
   localparam int BIT_PDOWN = 1;
   // Timer 2 flag register bit positions.
   localparam int BIT_T2_OVF = 0;
   localparam int BIT_T2_PIN = 1;
   // Machine cycle timing.
   localparam logic [3:0] PHASES_PER_CYCLE = 4'hc;
   localparam logic [3:0] PH_STATE2_PHASE2 = 4'h3;
   localparam logic [3:0] PH_STATE5_PHASE2 = 4'h9;
   localparam logic [1:0] IDLE_RESET_CYCLES = 2'h2;
endpackage : iepc_pkg

/* logic/iepc_sync2.sv */
// Purpose: Two-flop synchroniser for a group of asynchronous levels.
// Assumes: Inputs change slowly compared to pclk.
// Notes: The first stage is read only by the second stage.
`timescale 1ns/100ps
module iepc_sync2 #(
   parameter int WIDTH = 1,
   parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);
   typedef struct packed {
      logic [WIDTH-1:0] meta;
      logic [WIDTH-1:0] sync;
   } iepc_sync_s;

   iepc_sync_s s_q;
   iepc_sync_s s_d;

   always_comb begin
      s_d = s_q;
      s_d.meta = async_in;
      s_d.sync = s_q.meta;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_q <= {RESET_VAL, RESET_VAL};
      end else begin
         s_q <= s_d;
      end
   end

   assign sync_out = s_q.sync;
endmodule : iepc_sync2

/* logic/iepc_top.sv */
// Purpose: Interrupt enable masking, timer 2 flags and idle/power-down
//    control, reached by software over APB.
// Assumes: Timer 0/1 flags and serial request come from logic on pclk;
//    request pins and the reset pin are asynchronous.
// Notes: pclk is the oscillator; a divide-by-two enable forms phases.
//
// Decided for this implementation: the APB interface to the registers and the address map.
`timescale 1ns/100ps
//
// Overview of operation
// - Six sources: two low-active pins, timers 0, 1, 2, serial port.
// - Each source has its own enable bit; one allows, zero masks.
// - Global enable at bit 7 blocks all requests when zero.
// - Enable bits: t2 5, serial 4, t1 3, pin1 2, t0 1, pin0 0.
// - Timer 2 request is OR of its overflow and pin flags.
// - Timer 2 flags are never cleared on service; software clears.
// - Timer 0/1 flags set at state 5 phase 2, polled next cycle.
// - Timer 2 overflow flag set at state 2 phase 2, polled same cycle; here it is set on the event, at any phase.
// - Oscillator input passes a divide-by-two stage; no duty demand.
// - Idle stops the CPU; peripherals keep running.
// - Idle keeps RAM and special registers unchanged.
// - Idle ends on any enabled interrupt request or hardware reset.
// - Reset ending idle: two cycles with RAM writes blocked, ports open.
// - Power-down stops the oscillator after the requesting instruction.
// - Power-down keeps state; only hardware reset ends it.
// - Reset after power-down reinitialises registers, keeps RAM.
// - Idle drives strobes high, power-down low; port pin states per mode.
// - In up/down mode the pin flag toggles and raises no request.
// - In baud generator mode rollover sets no flag and no request.
module iepc_top (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [iepc_pkg::ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic ext_request0_n,
   input wire logic ext_request1_n,
   input wire logic hw_reset_pin,
   input wire logic t0_overflow_flag,
   input wire logic t1_overflow_flag,
   input wire logic serial_request,
   input wire logic t2_overflow_event,
   input wire logic t2_pin_event,
   input wire logic t2_updown_mode,
   input wire logic t2_baud_mode,
   input wire logic ext_prog_mem,
   input wire logic cpu_ale,
   input wire logic cpu_prog_store_strobe_n,
   input wire logic cpu_port2_addr,
   output logic [iepc_pkg::NUM_SOURCES-1:0] irq_request,
   output logic phase_tick,
   output logic cpu_clk_en,
   output logic periph_clk_en,
   output logic osc_stop,
   output logic ram_write_block,
   output logic sfr_reset,
   output logic ale,
   output logic prog_store_strobe_n,
   output logic port0_float,
   output logic port2_addr_sel,
   output logic port_hold
);
   typedef struct packed {
      logic [7:0] irq_en;
      logic idle;
      logic pdown;
      logic t2_ovf;
      logic t2_pin;
      logic [1:0] t01_cap;
      logic [1:0] t01_poll;
      logic div;
      logic [3:0] phase;
      logic rst_prev;
      logic [1:0] idle_rst_cnt;
      logic ram_block;
      logic sfr_rst;
      logic [iepc_pkg::NUM_SOURCES-1:0] irq;
      logic phase_tick;
      logic cpu_en;
      logic periph_en;
      logic osc_stop;
      logic ale;
      logic prog_store_strobe_n_n;
      logic p0_float;
      logic p2_addr;
      logic hold;
      logic pready;
      logic pslverr;
      logic [31:0] prdata;
   } iepc_state_s;

   iepc_state_s s_q;
   iepc_state_s s_d;
   logic [2:0] pins_sync;
   logic pin0_active;
   logic pin1_active;
   logic rst_active;

   iepc_sync2 #(
      .WIDTH(3),
      .RESET_VAL(3'h3)
   ) u_sync (
      .pclk(pclk),
      .presetn(presetn),
      .async_in({hw_reset_pin, ext_request1_n, ext_request0_n}),
      .sync_out(pins_sync)
   );

   assign pin0_active = ~pins_sync[0];
   assign pin1_active = ~pins_sync[1];
   assign rst_active = pins_sync[2];

   // Decodes an APB offset; returns 1 when a register lives there.
   function automatic logic iepc_mapped(input logic [7:0] ofs);
      iepc_mapped = (ofs == iepc_pkg::OFS_IRQ_EN) ||
                    (ofs == iepc_pkg::OFS_MODE) ||
                    (ofs == iepc_pkg::OFS_T2_FLAGS) ||
                    (ofs == iepc_pkg::OFS_STATUS);
   endfunction : iepc_mapped

   always_comb begin
      logic setup;
      logic wr_acc;
      logic cycle_end;
      logic stepping;
      logic [5:0] pending;
      logic [iepc_pkg::NUM_SOURCES-1:0] req;
      logic t2_ovf_set;
      logic t2_pin_tgl;
      logic t2_pin_set;
      logic rst_rise;
      setup = 1'b0;
      wr_acc = 1'b0;
      cycle_end = 1'b0;
      stepping = 1'b0;
      pending = '0;
      req = '0;
      t2_ovf_set = 1'b0;
      t2_pin_tgl = 1'b0;
      t2_pin_set = 1'b0;
      rst_rise = 1'b0;
      s_d = s_q;

      // The oscillator only feeds phases through the halving stage, so
      // its duty cycle never shapes a phase length.
      // Power-down freezes the phase chain as the oscillator stops.
      s_d.div = s_q.pdown ? s_q.div : ~s_q.div;
      stepping = s_q.div && !s_q.pdown;
      if (stepping) begin
         if (s_q.phase == iepc_pkg::PHASES_PER_CYCLE - 4'h1) begin
            s_d.phase = 4'h0;
            cycle_end = 1'b1;
         end else begin
            s_d.phase = s_q.phase + 4'h1;
         end
      end
      s_d.phase_tick = stepping;

      // Timer 0/1 flags are captured at state 5 phase 2 and handed to
      // the poll stage when the next machine cycle begins.
      if (stepping && s_q.phase == iepc_pkg::PH_STATE5_PHASE2) begin
         s_d.t01_cap = {t1_overflow_flag, t0_overflow_flag};
      end
      if (cycle_end) begin
         s_d.t01_poll = s_q.t01_cap;
      end

      // Timer 2 overflow sets the flag in any phase; a baud generator
      // rollover sets nothing.
      t2_ovf_set = t2_overflow_event && !t2_baud_mode;
      // In up/down mode the pin flag toggles on each roll.
      t2_pin_tgl = t2_overflow_event && t2_updown_mode && !t2_baud_mode;
      t2_pin_set = t2_pin_event && !t2_updown_mode;

      // APB: setup registers the answer, access completes with pready.
      setup = psel && !penable;
      wr_acc = psel && penable && pwrite && s_q.pready;
      s_d.pready = setup;
      s_d.pslverr = setup && !iepc_mapped(paddr);
      if (setup) begin
         s_d.prdata = 32'h0;
         case (paddr)
            iepc_pkg::OFS_IRQ_EN: begin
               s_d.prdata[7:0] = s_q.irq_en;
            end
            iepc_pkg::OFS_MODE: begin
               s_d.prdata[iepc_pkg::BIT_IDLE] = s_q.idle;
               s_d.prdata[iepc_pkg::BIT_PDOWN] = s_q.pdown;
            end
            iepc_pkg::OFS_T2_FLAGS: begin
               s_d.prdata[iepc_pkg::BIT_T2_OVF] = s_q.t2_ovf;
               s_d.prdata[iepc_pkg::BIT_T2_PIN] = s_q.t2_pin;
            end
            iepc_pkg::OFS_STATUS: begin
               s_d.prdata[5:0] = s_q.irq;
               s_d.prdata[8] = s_q.ram_block;
               s_d.prdata[9] = s_q.cpu_en;
               s_d.prdata[13:10] = s_q.phase;
            end
            default: begin
               s_d.prdata = 32'h0;
            end
         endcase
      end

      if (wr_acc) begin
         case (paddr)
            iepc_pkg::OFS_IRQ_EN: begin
               // Reserved bit 6 is not stored, so a stray one is
               // harmless here.
               s_d.irq_en = pwdata[7:0] & iepc_pkg::IRQ_EN_WMASK;
            end
            iepc_pkg::OFS_MODE: begin
               // Power-down wins when both bits are written.
               if (pwdata[iepc_pkg::BIT_PDOWN]) begin
                  s_d.pdown = 1'b1;
                  s_d.idle = 1'b0;
               end else if (pwdata[iepc_pkg::BIT_IDLE]) begin
                  s_d.idle = 1'b1;
               end
            end
            iepc_pkg::OFS_T2_FLAGS: begin
               // Service never clears these; software writes one to clear.
               if (pwdata[iepc_pkg::BIT_T2_OVF]) begin
                  s_d.t2_ovf = 1'b0;
               end
               if (pwdata[iepc_pkg::BIT_T2_PIN]) begin
                  s_d.t2_pin = 1'b0;
               end
            end
            default: begin
            end
         endcase
      end

      // Hardware sets after the software clear so an event in the same
      // cycle is kept.
      if (t2_ovf_set) begin
         s_d.t2_ovf = 1'b1;
      end
      if (t2_pin_tgl) begin
         s_d.t2_pin = ~s_d.t2_pin;
      end else if (t2_pin_set) begin
         s_d.t2_pin = 1'b1;
      end

      // Six sources, positioned as the enable mask.
      pending[iepc_pkg::BIT_PIN0] = pin0_active;
      pending[iepc_pkg::BIT_T0] = s_q.t01_poll[0];
      pending[iepc_pkg::BIT_PIN1] = pin1_active;
      pending[iepc_pkg::BIT_T1] = s_q.t01_poll[1];
      pending[iepc_pkg::BIT_SERIAL] = serial_request;
      // Pin flag does not request in up/down mode.
      pending[iepc_pkg::BIT_T2] = s_q.t2_ovf ||
                                  (s_q.t2_pin && !t2_updown_mode);
      // Per-source mask under the global gate.
      req = pending[iepc_pkg::NUM_SOURCES-1:0] &
            s_q.irq_en[iepc_pkg::NUM_SOURCES-1:0] &
            {iepc_pkg::NUM_SOURCES{s_q.irq_en[iepc_pkg::BIT_GLOBAL]}};
      s_d.irq = req;

      // Any enabled request wakes from idle; power-down ignores it.
      if (s_q.idle && (|req)) begin
         s_d.idle = 1'b0;
      end

      // Hardware reset pin handling.
      rst_rise = rst_active && !s_q.rst_prev;
      s_d.rst_prev = rst_active;
      if (rst_rise && s_q.idle) begin
         // Execution runs on for two cycles with RAM writes held off;
         // port accesses stay open.
         s_d.idle = 1'b0;
         s_d.idle_rst_cnt = iepc_pkg::IDLE_RESET_CYCLES;
         s_d.ram_block = 1'b1;
      end else if (s_q.idle_rst_cnt != 2'h0) begin
         if (cycle_end) begin
            s_d.idle_rst_cnt = s_q.idle_rst_cnt - 2'h1;
         end
         if (s_d.idle_rst_cnt == 2'h0) begin
            s_d.ram_block = 1'b0;
         end
      end
      s_d.sfr_rst = rst_active && (s_d.idle_rst_cnt == 2'h0);
      if (s_d.sfr_rst) begin
         // Internal reset reloads the registers; RAM is left alone, and
         // this is the only way out of power-down.
         s_d.irq_en = iepc_pkg::IRQ_EN_RESET;
         s_d.idle = 1'b0;
         s_d.pdown = 1'b0;
         s_d.t2_ovf = 1'b0;
         s_d.t2_pin = 1'b0;
         s_d.t01_cap = 2'h0;
         s_d.t01_poll = 2'h0;
         s_d.irq = '0;
         s_d.ram_block = 1'b0;
      end

      // Idle gates only the CPU; power-down stops everything.
      s_d.cpu_en = !s_d.idle && !s_d.pdown;
      s_d.periph_en = !s_d.pdown;
      s_d.osc_stop = s_d.pdown;
      // The CPU is halted, so RAM and registers hold.
      s_d.hold = s_d.idle || s_d.pdown;

      // Pin states per mode.
      if (s_d.pdown) begin
         s_d.ale = 1'b0;
         s_d.prog_store_strobe_n_n = 1'b0;
         s_d.p0_float = ext_prog_mem;
         s_d.p2_addr = 1'b0;
      end else if (s_d.idle) begin
         s_d.ale = 1'b1;
         s_d.prog_store_strobe_n_n = 1'b1;
         s_d.p0_float = ext_prog_mem;
         s_d.p2_addr = ext_prog_mem;
      end else begin
         s_d.ale = cpu_ale;
         s_d.prog_store_strobe_n_n = cpu_prog_store_strobe_n;
         s_d.p0_float = 1'b0;
         s_d.p2_addr = cpu_port2_addr;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_q <= '0;
         s_q.irq_en <= iepc_pkg::IRQ_EN_RESET;
         s_q.rst_prev <= 1'b1;
         s_q.sfr_rst <= 1'b1;
         s_q.cpu_en <= 1'b1;
         s_q.periph_en <= 1'b1;
         s_q.prog_store_strobe_n_n <= 1'b1;
      end else begin
         s_q <= s_d;
      end
   end

   assign prdata = s_q.prdata;
   assign pready = s_q.pready;
   assign pslverr = s_q.pslverr;
   assign irq_request = s_q.irq;
   assign phase_tick = s_q.phase_tick;
   assign cpu_clk_en = s_q.cpu_en;
   assign periph_clk_en = s_q.periph_en;
   assign osc_stop = s_q.osc_stop;
   assign ram_write_block = s_q.ram_block;
   assign sfr_reset = s_q.sfr_rst;
   assign ale = s_q.ale;
   assign prog_store_strobe_n = s_q.prog_store_strobe_n_n;
   assign port0_float = s_q.p0_float;
   assign port2_addr_sel = s_q.p2_addr;
   assign port_hold = s_q.hold;
endmodule : iepc_top

/* dv/iepc_props.sv */
// Purpose: Port checks for the interrupt enable and low-power block.
// Assumes: Sees only the ports of iepc_top; one clock domain.
// Notes: Idle shows as cpu_clk_en low while osc_stop is low.
`timescale 1ns/100ps
module iepc_props (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic hw_reset_pin,
   input wire logic ext_prog_mem,
   input wire logic [iepc_pkg::NUM_SOURCES-1:0] irq_request,
   input wire logic phase_tick,
   input wire logic cpu_clk_en,
   input wire logic periph_clk_en,
   input wire logic osc_stop,
   input wire logic ram_write_block,
   input wire logic sfr_reset,
   input wire logic ale,
   input wire logic prog_store_strobe_n,
   input wire logic port0_float
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   sequence s_idle;
      !cpu_clk_en && !osc_stop;
   endsequence
   sequence s_tick_gap;
      phase_tick ##1 (!phase_tick && !osc_stop);
   endsequence
   tick_alt_a: assert property (phase_tick |=> !phase_tick)
      else $error("phase tick lasted two cycles");
   tick_gap_a: assert property (
      s_tick_gap |=> phase_tick || osc_stop)
      else $error("phase tick gap longer than one cycle");
   idle_periph_a: assert property (s_idle |-> periph_clk_en)
      else $error("peripheral clock stopped in idle");
   idle_strobe_a: assert property (
      s_idle |-> ale && prog_store_strobe_n)
      else $error("strobes not high in idle");
   // The wake decision and irq_request are registered at the same edge,
   // so a request seen one cycle after idle must already show the wake.
   idle_wake_a: assert property (
      s_idle ##1 (|irq_request && !osc_stop) |-> cpu_clk_en)
      else $error("enabled request did not end idle");
   pdown_pins_a: assert property (osc_stop |->
      !ale && !prog_store_strobe_n && !periph_clk_en)
      else $error("power-down outputs wrong");
   pdown_hold_a: assert property (osc_stop && !hw_reset_pin &&
      !$past(hw_reset_pin) |=> osc_stop)
      else $error("power-down left without reset");
   float_a: assert property (
      port0_float |-> ext_prog_mem && !cpu_clk_en)
      else $error("port 0 floats outside low-power external mode");
   // Two machine cycle ends of 24 clocks each, the first one partial.
   ram_block_a: assert property ($rose(ram_write_block) |->
      ##[25:48] sfr_reset)
      else $error("internal reset late after idle exit");
   pin_reset_a: assert property (
      $rose(hw_reset_pin) && cpu_clk_en |-> ##3 sfr_reset)
      else $error("internal reset did not follow pin");
endmodule : iepc_props
bind iepc_top iepc_props u_props (.pclk, .presetn, .hw_reset_pin,
   .ext_prog_mem, .irq_request, .phase_tick, .cpu_clk_en, .periph_clk_en,
   .osc_stop, .ram_write_block, .sfr_reset, .ale, .prog_store_strobe_n,
   .port0_float);

/* dv/iepc_far_model.sv */
// Purpose: Timers, serial port, request pins, reset pin and CPU pins.
// Assumes: The bench raises src_on bits to assert each source.
// Notes: Timer 2 overflow is a one-cycle pulse on a rising src_on bit; the pin event follows t2_pin_kick.
`timescale 1ns/100ps
module iepc_far_model (
   input wire logic pclk,
   input wire logic [5:0] src_on,
   input wire logic t2_pin_kick,
   input wire logic reset_kick,
   output logic ext_request0_n,
   output logic ext_request1_n,
   output logic t0_overflow_flag,
   output logic t1_overflow_flag,
   output logic serial_request,
   output logic t2_overflow_event,
   output logic t2_pin_event,
   output logic hw_reset_pin,
   output logic cpu_ale,
   output logic cpu_prog_store_strobe_n,
   output logic cpu_port2_addr
);
   logic src5_q = 1'b0;
   logic [5:0] rst_cnt_q = 6'h00;
   always_ff @(posedge pclk) begin
      src5_q <= src_on[5];
      if (reset_kick) begin
         rst_cnt_q <= 6'h3f;
      end else if (rst_cnt_q != 6'h00) begin
         rst_cnt_q <= rst_cnt_q - 6'h01;
      end
   end
   assign ext_request0_n = ~src_on[0];
   assign t0_overflow_flag = src_on[1];
   assign ext_request1_n = ~src_on[2];
   assign t1_overflow_flag = src_on[3];
   assign serial_request = src_on[4];
   assign t2_overflow_event = src_on[5] & ~src5_q;
   assign t2_pin_event = t2_pin_kick;
   // Held long enough for a restarted oscillator to settle, and past the
   // two machine cycles that an idle exit defers the reset.
   assign hw_reset_pin = rst_cnt_q != 6'h00;
   // Fixed CPU levels: the idle strobe override and the power-down ale and port 2 overrides are visible.
   // The CPU makes no port or external access after idle entry.
   assign cpu_ale = 1'b1;
   assign cpu_prog_store_strobe_n = 1'b0;
   assign cpu_port2_addr = 1'b1;
endmodule : iepc_far_model

/* dv/tb_top.sv */
// Purpose: Register, masking, idle and power-down tests over APB.
// Assumes: APB answers in one access cycle; pins need sync time.
// Notes: Settling waits cover the twelve-phase timer sampling.
`timescale 1ns/100ps
module tb_top;
   logic pclk = 1'b0;
   logic presetn, psel, penable, pwrite, pready, pslverr, err;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [5:0] src_on, irq_request;
   logic t2_pin_kick, reset_kick, t2_updown_mode, t2_baud_mode, ext_prog_mem;
   logic ext_request0_n, ext_request1_n, hw_reset_pin, t0_overflow_flag;
   logic t1_overflow_flag, serial_request, t2_overflow_event, t2_pin_event;
   logic cpu_ale, cpu_prog_store_strobe_n, cpu_port2_addr, phase_tick;
   logic cpu_clk_en, periph_clk_en, osc_stop, ram_write_block, sfr_reset;
   logic ale, prog_store_strobe_n, port0_float, port2_addr_sel, port_hold;
   int bad_count = 0;
   int cmp_count = 0;
   always #5 pclk = ~pclk;
   iepc_top uut (.*);
   iepc_far_model u_far (.*);
   task automatic tally_and_finish();
      $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : tally_and_finish
   task automatic chk(input string nm, input logic [31:0] e,
      input logic [31:0] g);
      cmp_count++;
      if (g !== e) begin
         bad_count++;
         $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   task automatic hang(input string nm);
      chk(nm, 32'h1, 32'h0);
      tally_and_finish();
   endtask : hang
   task automatic apb(input logic wr, input logic [7:0] a,
      input logic [31:0] d);
      int n;
      n = 0;
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1 && n < 20) begin
         n++;
         @(posedge pclk);
      end
      if (n == 20) hang("pready");
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask : apb
   task automatic expect_irq(input logic [5:0] e);
      int n;
      n = 0;
      while (irq_request !== e && n < 60) begin
         n++;
         @(posedge pclk);
      end
      if (n == 60) hang("irq_request");
      cmp_count++;
   endtask : expect_irq
   task automatic none_chk(input string nm);
      repeat (40) @(posedge pclk);
      chk(nm, 32'h0, {26'h0, irq_request});
   endtask : none_chk
   task automatic mode_chk(input string nm, input logic [6:0] e);
      repeat (6) @(posedge pclk);
      chk(nm, {25'h0, e}, {25'h0, cpu_clk_en, periph_clk_en, osc_stop, ale,
         prog_store_strobe_n, port0_float, port2_addr_sel});
   endtask : mode_chk
   task automatic kick(input logic rst);
      if (rst) reset_kick <= 1'b1;
      else t2_pin_kick <= 1'b1;
      @(posedge pclk);
      reset_kick <= 1'b0;
      t2_pin_kick <= 1'b0;
   endtask : kick
   initial begin
      int n;
      {presetn, psel, penable, pwrite, t2_pin_kick, reset_kick} = 6'h00;
      {t2_updown_mode, t2_baud_mode, ext_prog_mem} = 3'h0;
      paddr = 8'h00;
      pwdata = 32'h0;
      src_on = 6'h00;
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      apb(1'b0, iepc_pkg::OFS_IRQ_EN, 32'h0);
      chk("mask reset", 32'h0, rd);
      apb(1'b0, 8'h10, 32'h0);
      chk("unmapped", 32'h1, {31'h0, err});
      // Bit 6 is never written with a one.
      apb(1'b1, iepc_pkg::OFS_IRQ_EN, 32'hbf);
      apb(1'b0, iepc_pkg::OFS_IRQ_EN, 32'h0);
      chk("mask rw", 32'hbf, rd);
      for (int i = 0; i < 6; i++) begin
         apb(1'b1, iepc_pkg::OFS_IRQ_EN, 32'h80 | (32'h1 << i));
         src_on <= 6'h01 << i;
         expect_irq(6'h01 << i);
         apb(1'b1, iepc_pkg::OFS_IRQ_EN, 32'hbf & ~(32'h1 << i));
         none_chk("own bit masked");
         apb(1'b1, iepc_pkg::OFS_IRQ_EN, 32'h1 << i);
         none_chk("global off");
         src_on <= 6'h00;
         apb(1'b1, iepc_pkg::OFS_IRQ_EN, 32'h80 | (32'h1 << i));
         repeat (40) @(posedge pclk);
         chk("after source", (i == 5) ? 32'h20 : 32'h0, irq_request);
         apb(1'b1, iepc_pkg::OFS_T2_FLAGS, 32'h3);
         none_chk("flags cleared");
      end
      kick(1'b0);
      expect_irq(6'h20);
      apb(1'b0, iepc_pkg::OFS_STATUS, 32'h0);
      chk("status irq", 32'h20, {26'h0, rd[5:0]});
      apb(1'b1, iepc_pkg::OFS_T2_FLAGS, 32'h2);
      t2_updown_mode <= 1'b1;
      none_chk("pin flag cleared");
      kick(1'b0);
      none_chk("updown pin event");
      // An overflow in up/down mode still requests, and toggles the pin flag.
      src_on <= 6'h20;
      expect_irq(6'h20);
      src_on <= 6'h00;
      apb(1'b1, iepc_pkg::OFS_T2_FLAGS, 32'h1);
      none_chk("updown toggle");
      apb(1'b0, iepc_pkg::OFS_T2_FLAGS, 32'h0);
      chk("pin flag toggled", 32'h2, rd);
      apb(1'b1, iepc_pkg::OFS_T2_FLAGS, 32'h2);
      t2_updown_mode <= 1'b0;
      t2_baud_mode <= 1'b1;
      src_on <= 6'h20;
      none_chk("baud rollover");
      src_on <= 6'h00;
      t2_baud_mode <= 1'b0;
      ext_prog_mem <= 1'b1;
      apb(1'b1, iepc_pkg::OFS_IRQ_EN, 32'h81);
      apb(1'b1, iepc_pkg::OFS_MODE, 32'h1);
      mode_chk("idle pins", 7'b0101111);
      apb(1'b0, iepc_pkg::OFS_IRQ_EN, 32'h0);
      chk("mask in idle", 32'h81, rd);
      src_on <= 6'h01;
      expect_irq(6'h01);
      mode_chk("idle wake", 7'b1101001);
      src_on <= 6'h00;
      apb(1'b1, iepc_pkg::OFS_MODE, 32'h1);
      kick(1'b1);
      n = 0;
      while (ram_write_block !== 1'b1 && n < 40) begin
         n++;
         @(posedge pclk);
      end
      if (n == 40) hang("ram block");
      repeat (60) @(posedge pclk);
      apb(1'b0, iepc_pkg::OFS_IRQ_EN, 32'h0);
      chk("mask after idle reset", 32'h0, rd);
      apb(1'b1, iepc_pkg::OFS_IRQ_EN, 32'h81);
      apb(1'b1, iepc_pkg::OFS_MODE, 32'h3);
      mode_chk("pdown pins", 7'b0010010);
      src_on <= 6'h01;
      repeat (40) @(posedge pclk);
      chk("pdown holds", 32'h1, {31'h0, osc_stop});
      src_on <= 6'h00;
      kick(1'b1);
      repeat (60) @(posedge pclk);
      mode_chk("pdown exit", 7'b1101001);
      apb(1'b0, iepc_pkg::OFS_IRQ_EN, 32'h0);
      chk("mask after pdown", 32'h0, rd);
      apb(1'b1, iepc_pkg::OFS_IRQ_EN, 32'h81);
      kick(1'b1);
      repeat (60) @(posedge pclk);
      apb(1'b0, iepc_pkg::OFS_IRQ_EN, 32'h0);
      chk("mask after run reset", 32'h0, rd);
      tally_and_finish();
   end
endmodule : tb_top
